// ===== design/acc_cal_regs.sv
// calibration control and status register bank with a calibration sequencer
// What this block does
// - run switch high runs, low holds reset
// - low run switch resets digital dividers
// - bit 3 background offset, needs background
// - bit 2 foreground offset, needs foreground
// - bit 1 enables background calibration
// - bit 0 selects foreground run or skip
// - converter-off field picks disabled sub-converter, one-hot select only while background calibration is off
// - bits 6:4 offset averaging, reset 6
// - bits 2:0 linearity averaging, reset 1
// - status: code 4:2, halted 1, done 0
// - halted flag on stop, clear on resume
// - complete flag high after finish or skip
`include "acc_consts.svh"
module acc_cal_regs
  import acc_pkg::*;
(
  input wire logic i_clk_sys, // 25 MHz clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic [9:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte enables
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // stall
  output logic [1:0] o_avs_response, // 00 ok, 10 slave error
  output logic o_cal_rst, // calibration logic held in reset
  output logic o_div_rst, // digital and link clock dividers reset
  output logic o_serial_link_output_switch, // link enable
  output logic o_background_offset_on, // effective background offset
  output logic o_foreground_offset_on, // effective foreground offset
  output logic o_background_tracking_on, // background calibration on
  output logic [1:0] o_converter_off, // disabled sub-converter code
  output logic [2:0] o_sub_converter_off_onehot, // zero, one, two
  output logic [2:0] o_offset_averaging_depth, // offset averaging
  output logic [2:0] o_linearity_averaging_depth, // linearity averaging
  output logic o_foreground_complete_flag, // status bit 0
  output logic o_cal_halted // status bit 1
);

  // ==========================================================
  // state
  typedef struct packed {
    logic run;
    logic run_d;
    logic [3:0] cfg;
    logic [1:0] off;
    logic [2:0] ofs_depth;
    logic [2:0] lin_avg;
    logic link;
    logic halt_req;
    acc_state_t st;
    logic [15:0] cnt;
    logic fg_complete;
    logic halted;
    logic ack;
    logic [31:0] rdata;
    logic err;
  } acc_regs_t;

  acc_regs_t r_reg;
  acc_regs_t r_next;

  // ==========================================================
  // decode helpers
  function automatic logic idx_hit(input logic [9:0] addr, input logic [7:0] idx);
    idx_hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] status_code(input acc_state_t s);
    case (s)
      ST_HOLD: status_code = 3'h0;
      ST_FG_LIN: status_code = 3'h1;
      ST_FG_OFS: status_code = 3'h2;
      ST_BG_RUN: status_code = 3'h3;
      ST_HALTED: status_code = 3'h4;
      ST_DONE: status_code = 3'h5;
      default: status_code = 3'h7;
    endcase
  endfunction

  logic mapped;
  logic req;
  logic fg_sel;
  logic bg_sel;
  logic [15:0] pass_cyc;
  assign req = (i_avs_read | i_avs_write) & ~r_reg.ack;
  assign mapped = idx_hit(i_avs_address, `ACC_IDX_RUN) | idx_hit(i_avs_address, `ACC_IDX_CFG)
    | idx_hit(i_avs_address, `ACC_IDX_OFF) | idx_hit(i_avs_address, `ACC_IDX_AVG)
    | idx_hit(i_avs_address, `ACC_IDX_STAT) | idx_hit(i_avs_address, `ACC_IDX_LINK)
    | idx_hit(i_avs_address, `ACC_IDX_PHASE);
  assign fg_sel = r_reg.cfg[`ACC_BIT_FG];
  assign bg_sel = r_reg.cfg[`ACC_BIT_BG];
  assign pass_cyc = 16'(`ACC_PASS_CYC);

  // ==========================================================
  // next state
  always_comb
  begin
    r_next = r_reg;
    r_next.ack = 1'b0;
    r_next.run_d = r_reg.run;
    // bus: one wait cycle, answer on the second edge
    if (req)
    begin
      r_next.ack = 1'b1;
      r_next.err = ~mapped;
      r_next.rdata = 32'h0000_0000;
      if (i_avs_write && i_avs_byteenable[0])
      begin
        if (idx_hit(i_avs_address, `ACC_IDX_RUN))
          r_next.run = i_avs_writedata[0];
        if (idx_hit(i_avs_address, `ACC_IDX_CFG))
          r_next.cfg = i_avs_writedata[3:0];
        if (idx_hit(i_avs_address, `ACC_IDX_OFF))
          r_next.off = i_avs_writedata[1:0];
        if (idx_hit(i_avs_address, `ACC_IDX_AVG))
        begin
          r_next.ofs_depth = i_avs_writedata[6:4];
          r_next.lin_avg = i_avs_writedata[2:0];
        end
        if (idx_hit(i_avs_address, `ACC_IDX_LINK))
          r_next.link = i_avs_writedata[0];
        if (idx_hit(i_avs_address, `ACC_IDX_PHASE))
          r_next.halt_req = i_avs_writedata[0];
      end
      if (i_avs_read)
      begin
        if (idx_hit(i_avs_address, `ACC_IDX_RUN))
          r_next.rdata = {31'h0, r_reg.run};
        if (idx_hit(i_avs_address, `ACC_IDX_CFG))
          r_next.rdata = {28'h0, r_reg.cfg};
        if (idx_hit(i_avs_address, `ACC_IDX_OFF))
          r_next.rdata = {30'h0, r_reg.off};
        if (idx_hit(i_avs_address, `ACC_IDX_AVG))
          r_next.rdata = {25'h0, r_reg.ofs_depth, 1'b0, r_reg.lin_avg};
        if (idx_hit(i_avs_address, `ACC_IDX_STAT))
          r_next.rdata = {27'h0, status_code(r_reg.st), r_reg.halted, r_reg.fg_complete};
        if (idx_hit(i_avs_address, `ACC_IDX_LINK))
          r_next.rdata = {31'h0, r_reg.link};
        if (idx_hit(i_avs_address, `ACC_IDX_PHASE))
          r_next.rdata = {31'h0, r_reg.halt_req};
      end
    end

    // calibration sequencer
    if (!r_reg.run)
    begin
      // held in reset while switch low
      r_next.st = ST_HOLD;
      r_next.cnt = 16'h0000;
    end
    else
    begin
      case (r_reg.st)
        ST_HOLD:
        begin
          if (!r_reg.run_d)
          begin
            r_next.fg_complete = 1'b0;
            r_next.halted = 1'b0;
            r_next.cnt = 16'h0000;
            if (fg_sel)
              r_next.st = ST_FG_LIN;
            else
            begin
              r_next.fg_complete = 1'b1;
              r_next.halted = ~bg_sel;
              r_next.st = bg_sel ? ST_BG_RUN : ST_DONE;
            end
          end
        end
        ST_FG_LIN:
        begin
          r_next.cnt = r_reg.cnt + 16'h0001;
          if (r_reg.cnt >= pass_cyc - 16'h0001)
          begin
            r_next.cnt = 16'h0000;
            if (r_reg.cfg[`ACC_BIT_FGOS])
              r_next.st = ST_FG_OFS;
            else
            begin
              r_next.fg_complete = 1'b1;
              r_next.halted = ~bg_sel;
              r_next.st = bg_sel ? ST_BG_RUN : ST_DONE;
            end
          end
        end
        ST_FG_OFS:
        begin
          r_next.cnt = r_reg.cnt + 16'h0001;
          if (r_reg.cnt >= `ACC_OFS_CYC - 16'h0001)
          begin
            r_next.cnt = 16'h0000;
            r_next.fg_complete = 1'b1;
            r_next.halted = ~bg_sel;
            r_next.st = bg_sel ? ST_BG_RUN : ST_DONE;
          end
        end
        ST_BG_RUN:
        begin
          if (r_reg.halt_req)
          begin
            r_next.halted = 1'b1;
            r_next.st = ST_HALTED;
          end
        end
        ST_HALTED:
        begin
          if (!r_reg.halt_req)
          begin
            r_next.halted = 1'b0;
            r_next.st = ST_BG_RUN;
          end
        end
        ST_DONE:
        begin
          if (bg_sel)
          begin
            r_next.halted = 1'b0;
            r_next.st = ST_BG_RUN;
          end
        end
        default:
          r_next.st = ST_HOLD;
      endcase
    end
  end

  // ==========================================================
  // registers
  // reset bytes kept with the other constants, fields sliced out here
  localparam logic [7:0] run_rst_val = `ACC_RST_RUN;
  localparam logic [7:0] cfg_rst_val = `ACC_RST_CFG;
  localparam logic [7:0] off_rst_val = `ACC_RST_OFF;
  localparam logic [7:0] avg_rst_val = `ACC_RST_AVG;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
      r_reg.run <= run_rst_val[0];
      r_reg.cfg <= cfg_rst_val[3:0];
      r_reg.off <= off_rst_val[1:0];
      r_reg.ofs_depth <= avg_rst_val[6:4];
      r_reg.lin_avg <= avg_rst_val[2:0];
      r_reg.st <= ST_HOLD;
    end
    else if (i_ce)
      r_reg <= r_next;
  end

  // ==========================================================
  // outputs
  // an ack frozen by a low enable must not finish a fresh request
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~(r_reg.ack & i_ce);
  assign o_avs_readdata = r_reg.rdata;
  assign o_avs_response = r_reg.err ? 2'b10 : 2'b00;
  assign o_cal_rst = ~r_reg.run;
  assign o_div_rst = ~r_reg.run;
  assign o_serial_link_output_switch = r_reg.link & r_reg.run;
  assign o_background_offset_on = r_reg.cfg[`ACC_BIT_BGOS] & bg_sel & r_reg.run;
  assign o_foreground_offset_on = r_reg.cfg[`ACC_BIT_FGOS] & fg_sel;
  assign o_background_tracking_on = bg_sel & r_reg.run;
  assign o_converter_off = r_reg.off;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_off
      assign o_sub_converter_off_onehot[g] = ~bg_sel & (r_reg.off == 2'(g));
    end
  endgenerate

  assign o_offset_averaging_depth = r_reg.ofs_depth;
  assign o_linearity_averaging_depth = r_reg.lin_avg;
  assign o_foreground_complete_flag = r_reg.fg_complete;
  assign o_cal_halted = r_reg.halted;

  // ==========================================================
  // checks
  AST_RUN_LOW_HOLDS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && !r_reg.run) |=> (r_reg.st == ST_HOLD)) else $error("sequencer not held");
  AST_DIV_RESET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_div_rst == o_cal_rst) else $error("divider reset mismatch");
  AST_LINK_GATED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_serial_link_output_switch |-> r_reg.run) else $error("link on without run");
  AST_BGOS_NEEDS_BG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_background_offset_on |-> o_background_tracking_on) else $error("bg offset alone");
  AST_FGOS_NEEDS_FG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (r_reg.st == ST_FG_OFS) |-> fg_sel) else $error("fg offset without fg");
  AST_SKIP_DONE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && r_reg.run && !r_reg.run_d && r_reg.st == ST_HOLD && !fg_sel) |=> r_reg.fg_complete)
    else $error("skip not complete");
  AST_OFF_ONEHOT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $countones(o_sub_converter_off_onehot) <= 1) else $error("two converters off");
  AST_HALT_FLAG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && r_reg.run && r_reg.st == ST_BG_RUN && r_reg.halt_req) |=> o_cal_halted)
    else $error("halt not flagged");
  AST_RESTART_CLEARS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && r_reg.run && !r_reg.run_d && r_reg.st == ST_HOLD && fg_sel) |=> !r_reg.fg_complete)
    else $error("restart kept flag");
  AST_BUS_ANSWER: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && req) ##1 i_ce |-> !o_avs_waitrequest)
    else $error("bus answer late");
  AST_RESUME_CLEARS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && r_reg.run && r_reg.st == ST_HALTED && !r_reg.halt_req) |=> !o_cal_halted)
    else $error("halted kept after resume");
  AST_COMPLETE_STAYS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && r_reg.run && r_reg.run_d && r_reg.fg_complete) |=> r_reg.fg_complete)
    else $error("complete flag dropped");
  AST_LIN_PASS_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (r_reg.st == ST_FG_LIN) |-> (r_reg.cnt < pass_cyc))
    else $error("linearity pass overran");

endmodule // acc_cal_regs

// ===== design/acc_consts.svh
// constants for the calibration control register bank
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// register indices (byte address is four times the index)
`define ACC_IDX_RUN 8'h61
`define ACC_IDX_CFG 8'h62
`define ACC_IDX_OFF 8'h64
`define ACC_IDX_AVG 8'h68
`define ACC_IDX_STAT 8'h6A
`define ACC_IDX_LINK 8'h70
`define ACC_IDX_PHASE 8'h71
// reset values
`define ACC_RST_RUN 8'h01
`define ACC_RST_CFG 8'h01
`define ACC_RST_OFF 8'h02
`define ACC_RST_AVG 8'h61
// field positions
`define ACC_BIT_BGOS 3
`define ACC_BIT_FGOS 2
`define ACC_BIT_BG 1
`define ACC_BIT_FG 0
// timing of the modelled calibration pass
`define ACC_PASS_US 20
`define ACC_CLK_MHZ 25
`define ACC_PASS_CYC (`ACC_PASS_US * `ACC_CLK_MHZ)
`define ACC_OFS_CYC 16'h0040
`endif

// ===== design/acc_pkg.sv
// types for the calibration control register bank
package acc_pkg;
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_FG_LIN,
    ST_FG_OFS,
    ST_BG_RUN,
    ST_HALTED,
    ST_DONE
  } acc_state_t;
endpackage

// ===== tb/adc_calibration_control_regs_bench.sv
// self-checking bench for the calibration control register bank
`include "acc_consts.svh"
module adc_calibration_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import acc_pkg::*;
  logic clk, rst, ce, rd, wr, wreq, crst, drst, lnk, bgos, fgos, bgt, done, halt;
  logic [9:0] adr;
  logic [31:0] wd, rdata, q;
  logic [3:0] be;
  logic [1:0] resp, coff, r;
  logic [2:0] oh, oavg, lavg;
  logic [7:0] c, o, a, s;
  int err_count, tests_run;
  logic [7:0] ridx [4] = '{`ACC_IDX_RUN, `ACC_IDX_CFG, `ACC_IDX_OFF, `ACC_IDX_AVG};
  logic [7:0] rval [4] = '{8'h01, 8'h01, 8'h02, 8'h61};

  acc_cal_regs DUT (
    .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_avs_response(resp), .o_cal_rst(crst), .o_div_rst(drst),
    .o_serial_link_output_switch(lnk), .o_background_offset_on(bgos),
    .o_foreground_offset_on(fgos), .o_background_tracking_on(bgt), .o_converter_off(coff),
    .o_sub_converter_off_onehot(oh), .o_offset_averaging_depth(oavg),
    .o_linearity_averaging_depth(lavg), .o_foreground_complete_flag(done), .o_cal_halted(halt)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================
  // helpers
  task automatic tally_and_finish();
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // one access; waitrequest sampled at each rising edge, data taken at the edge it is low
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d, input logic [3:0] b);
    int n;
    @(posedge clk);
    adr <= {i, 2'b00};
    rd <= ~w;
    wr <= w;
    wd <= {24'h0, d};
    be <= b;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    q = rdata;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      chk("waitrequest", 0, wreq);
      tally_and_finish();
    end
  endtask

  task automatic wait_lvl(input int sel, input logic v, input int lim);
    int n;
    n = 0;
    while ((sel ? halt : done) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk(sel ? "halted" : "fg complete", v, sel ? halt : done);
    if (n >= lim)
      tally_and_finish();
  endtask

  function automatic logic [2:0] exp_oh(input logic bg, input logic [1:0] k);
    exp_oh = (bg || k == 2'h3) ? 3'h0 : 3'h1 << k;
  endfunction

  // settled status: tracking code 3 with complete, or done code 5 with halted and complete
  function automatic logic [31:0] exp_stat(input logic bg);
    exp_stat = bg ? {27'h0, 3'h3, 2'b01} : {27'h0, 3'h5, 2'b11};
  endfunction

  // ==========================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 10'h000;
    wd = 32'h0;
    be = 4'h0;
    ce = 1'b1;
    err_count = 0;
    tests_run = 0;
    void'($urandom(32'h0B3418B5));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      bus(0, ridx[k], 8'h00, 4'hF);
      chk("reset value", {24'h0, rval[k]}, q);
    end
    chk("ofs avg", 3'h6, oavg);
    chk("lin avg", 3'h1, lavg);
    wait_lvl(0, 1'b1, 700);
    bus(0, 8'h00, 8'h00, 4'hF);
    chk("unmapped resp", 2'h2, r);
    chk("unmapped data", 32'h0, q);
    for (int i = 0; i < 6; i++)
    begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'h0F : 8'($urandom % 16);
      o = 8'($urandom % 4);
      a = 8'($urandom) & 8'h77;
      bus(1, `ACC_IDX_RUN, 8'h00, 4'hF);
      @(negedge clk);
      chk("cal_rst", 1, crst);
      chk("div_rst", 1, drst);
      bus(1, `ACC_IDX_CFG, c, 4'hF);
      bus(1, `ACC_IDX_OFF, o, 4'hF);
      bus(1, `ACC_IDX_AVG, a, 4'hF);
      bus(1, `ACC_IDX_RUN, 8'h01, 4'hF);
      repeat (2) @(negedge clk);
      chk("cal_rst", 0, crst);
      chk("bg offset", c[3] & c[1], bgos);
      chk("fg offset", c[2] & c[0], fgos);
      chk("bg tracking", c[1], bgt);
      chk("converter off", o[1:0], coff);
      chk("off onehot", exp_oh(c[1], o[1:0]), oh);
      chk("ofs avg", a[6:4], oavg);
      chk("lin avg", a[2:0], lavg);
      if (c[0])
        chk("foreground_complete_flag", 0, done);
      wait_lvl(0, 1'b1, c[0] ? 700 : 4);
      chk("halted", !c[1], halt);
      bus(0, `ACC_IDX_STAT, 8'h00, 4'hF);
      chk("status", exp_stat(c[1]), q);
      if (c[1])
      begin
        bus(1, `ACC_IDX_PHASE, 8'h01, 4'hF);
        wait_lvl(1, 1'b1, 8);
        bus(1, `ACC_IDX_PHASE, 8'h00, 4'hF);
        wait_lvl(1, 1'b0, 8);
      end
      bus(0, `ACC_IDX_CFG, 8'h00, 4'hF);
      chk("cfg readback", c, q);
      bus(0, `ACC_IDX_AVG, 8'h00, 4'hF);
      chk("avg readback", a, q);
    end
    // status must ignore writes
    bus(0, `ACC_IDX_STAT, 8'h00, 4'hF);
    s = q[7:0];
    bus(1, `ACC_IDX_STAT, 8'hFF, 4'hF);
    bus(0, `ACC_IDX_STAT, 8'h00, 4'hF);
    chk("status ro", s, q);
    bus(1, `ACC_IDX_AVG, 8'h00, 4'hE);
    bus(0, `ACC_IDX_AVG, 8'h00, 4'hF);
    chk("lane0 off", a, q);
    // link raised only after run is up, dropped first
    bus(1, `ACC_IDX_LINK, 8'h01, 4'hF);
    @(negedge clk);
    chk("link on", 1, lnk);
    bus(1, `ACC_IDX_LINK, 8'h00, 4'hF);
    @(negedge clk);
    chk("link off", 0, lnk);
    // enable low must freeze a pass in flight
    bus(1, `ACC_IDX_RUN, 8'h00, 4'hF);
    bus(1, `ACC_IDX_CFG, 8'h01, 4'hF);
    bus(1, `ACC_IDX_RUN, 8'h01, 4'hF);
    @(negedge clk);
    chk("fg complete", 0, done);
    @(posedge clk);
    ce <= 1'b0;
    repeat (600) @(negedge clk);
    chk("frozen fg complete", 0, done);
    @(posedge clk);
    ce <= 1'b1;
    wait_lvl(0, 1'b1, 700);
    chk("halted", 1, halt);
    tally_and_finish();
  end
endmodule // adc_calibration_control_regs_bench
